// >>> core/sled_defs.vh
// Constants shared by the status LED indicator files
`ifndef SLED_DEFS_VH
`define SLED_DEFS_VH

// ----------------------------------------------------------------
// Clock and timing figures
// ----------------------------------------------------------------
`define SLED_CLK_HZ 100000000
`define SLED_CYC_PER_MS (`SLED_CLK_HZ / 1000)
`define SLED_GREEN_MS 3000
`define SLED_OFLASH_MS 2000
`define SLED_FAST_HALF_MS 100
`define SLED_SLOW_HALF_MS 400
`define SLED_GAP_MS 2000
`define SLED_RAMP_START_MS 500
`define SLED_RAMP_MIN_MS 50
`define SLED_RAMP_STEP_MS 25
`define SLED_TRIG_TIMEOUT_MS 5000
`define SLED_GREEN_CYC (`SLED_GREEN_MS * `SLED_CYC_PER_MS)
`define SLED_OFLASH_CYC (`SLED_OFLASH_MS * `SLED_CYC_PER_MS)
`define SLED_FAST_HALF_CYC (`SLED_FAST_HALF_MS * `SLED_CYC_PER_MS)
`define SLED_SLOW_HALF_CYC (`SLED_SLOW_HALF_MS * `SLED_CYC_PER_MS)
`define SLED_GAP_CYC (`SLED_GAP_MS * `SLED_CYC_PER_MS)
`define SLED_RAMP_START_CYC (`SLED_RAMP_START_MS * `SLED_CYC_PER_MS)
`define SLED_RAMP_MIN_CYC (`SLED_RAMP_MIN_MS * `SLED_CYC_PER_MS)
`define SLED_RAMP_STEP_CYC (`SLED_RAMP_STEP_MS * `SLED_CYC_PER_MS)
`define SLED_TRIG_TIMEOUT_CYC (`SLED_TRIG_TIMEOUT_MS * `SLED_CYC_PER_MS)

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SLED_OFS_CTRL 8'h00
`define SLED_OFS_COND 8'h04
`define SLED_OFS_IRQ_STAT 8'h08
`define SLED_OFS_IRQ_MASK 8'h0c
`define SLED_OFS_LED_STATE 8'h10

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SLED_NCOND 9
`define SLED_CTRL_RESET 2'h3
`define SLED_CTRL_CHECKS 0
`define SLED_CTRL_TRIG_WD 1
`define SLED_SW_CLR_MASK 9'h1be
`define SLED_C_OVP 0
`define SLED_C_GEN 1
`define SLED_C_FW 2
`define SLED_C_PSET 3
`define SLED_C_PARAM 4
`define SLED_C_SERIAL 5
`define SLED_C_GEN3 6
`define SLED_C_RATE 7
`define SLED_C_TRIG 8

// ----------------------------------------------------------------
// Pattern encoding: kind, flash count, colour {red, green}
// ----------------------------------------------------------------
`define SLED_K_SOLID 3'h0
`define SLED_K_FAST 3'h1
`define SLED_K_SLOW 3'h2
`define SLED_K_RAMP 3'h3
`define SLED_K_GROUP 3'h4
`define SLED_COL_OFF 2'h0
`define SLED_COL_GREEN 2'h1
`define SLED_COL_RED 2'h2
`define SLED_COL_ORANGE 2'h3

`endif

// >>> core/sled_flash.v
// Flash pattern generator driving the two LED colour lines
`timescale 1ns/1ns
`include "sled_defs.vh"

module sled_flash
#(
  parameter FAST_HALF = `SLED_FAST_HALF_CYC,
  parameter SLOW_HALF = `SLED_SLOW_HALF_CYC,
  parameter GAP = `SLED_GAP_CYC,
  parameter RAMP_START = `SLED_RAMP_START_CYC,
  parameter RAMP_MIN = `SLED_RAMP_MIN_CYC,
  parameter RAMP_STEP = `SLED_RAMP_STEP_CYC
)
(
  input wire core_clk,
  input wire arst_n,
  input wire [2:0] kind,
  input wire [2:0] count,
  input wire [1:0] color,
  output wire [1:0] led
);

  // ----------------------------------------------------------------
  // Phase timing state
  // ----------------------------------------------------------------
  reg [31:0] cnt; // Cycles spent in the current phase
  reg lit; // Colour shown in this phase
  reg in_gap; // Dark pause between flash groups
  reg [2:0] done_n; // Flashes finished in the current group
  reg [31:0] ramp_half; // Current half period of the busy ramp
  reg [7:0] last_code; // Pattern seen last cycle, for restart
  wire [7:0] code = {kind, count, color};
  wire restart = (code != last_code);
  reg [31:0] cur_len;

  // Length of the phase now running
  always @*
  begin
    if (in_gap)
      cur_len = GAP;
    else if (kind == `SLED_K_FAST)
      cur_len = FAST_HALF;
    else if (kind == `SLED_K_RAMP)
      cur_len = ramp_half;
    else
      cur_len = SLOW_HALF;
  end

  // Phase sequencer; a pattern change restarts cleanly so a new
  // group never begins mid-flash and confuses the count
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt <= 32'h0000_0000;
      lit <= 1'b1;
      in_gap <= 1'b0;
      done_n <= 3'h0;
      ramp_half <= RAMP_START;
      last_code <= 8'h00;
    end
    else
    begin
      last_code <= code;
      if (restart)
      begin
        cnt <= 32'h0000_0000;
        lit <= 1'b1;
        in_gap <= 1'b0;
        done_n <= 3'h0;
        ramp_half <= RAMP_START;
      end
      else if (cnt >= cur_len - 32'h1)
      begin
        cnt <= 32'h0000_0000;
        if (in_gap)
        begin
          // Pause over, next group opens lit
          in_gap <= 1'b0;
          lit <= 1'b1;
        end
        else if (lit)
        begin
          lit <= 1'b0;
          if (kind == `SLED_K_GROUP && done_n == count - 3'h1)
          begin
            // Last flash of the group: take the long pause
            in_gap <= 1'b1;
            done_n <= 3'h0;
          end
          else
            done_n <= done_n + 3'h1;
        end
        else
          lit <= 1'b1;
        // Busy ramp shortens each phase until its floor
        if (ramp_half > RAMP_MIN + RAMP_STEP)
          ramp_half <= ramp_half - RAMP_STEP;
        else
          ramp_half <= RAMP_MIN;
      end
      else
        cnt <= cnt + 32'h1;
    end
  end

  // Solid shows colour always; others only in lit phases
  assign led = (kind == `SLED_K_SOLID || (lit && !in_gap)) ? color : `SLED_COL_OFF;

endmodule // sled_flash

// >>> core/sled_top.v
// Status LED error indicator with AHB-Lite register slave
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
`include "sled_defs.vh"

module sled_top
#(
  parameter GREEN_CYC = `SLED_GREEN_CYC,
  parameter OFLASH_CYC = `SLED_OFLASH_CYC,
  parameter FAST_HALF = `SLED_FAST_HALF_CYC,
  parameter SLOW_HALF = `SLED_SLOW_HALF_CYC,
  parameter GAP = `SLED_GAP_CYC,
  parameter RAMP_START = `SLED_RAMP_START_CYC,
  parameter RAMP_MIN = `SLED_RAMP_MIN_CYC,
  parameter RAMP_STEP = `SLED_RAMP_STEP_CYC,
  parameter TRIG_TIMEOUT = `SLED_TRIG_TIMEOUT_CYC
)
(
  input wire core_clk,
  input wire arst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Condition sources
  input wire boot_done,
  input wire ovp_flag,
  input wire gen_error,
  input wire fw_missing,
  input wire fw_boot_fail,
  input wire pset_bad,
  input wire param_bad,
  input wire [6:0] serial_fault,
  input wire gen3_error,
  input wire gen_ok,
  input wire busy,
  input wire line_rate_over,
  input wire line_trigger_input,
  // Indicator and power outputs
  output reg led_green,
  output reg led_red,
  output reg sensor_power_en,
  output reg live_image_en,
  output reg irq
);

  // ----------------------------------------------------------------
  // Power-on sequence states, one-hot
  // ----------------------------------------------------------------
  localparam [2:0] S_GREEN = 3'h1;
  localparam [2:0] S_OFLASH = 3'h2;
  localparam [2:0] S_RUN = 3'h4;

  reg [2:0] seq; // Current power-on phase
  reg [31:0] seq_cnt; // Cycles in the current phase
  reg [1:0] ctrl; // Checks enable, trigger watchdog enable
  reg [8:0] cond; // Latched error conditions
  reg [8:0] irq_stat; // Sticky interrupt status
  reg [8:0] irq_mask; // Interrupt enables
  reg [31:0] trig_cnt; // Cycles since the trigger last toggled
  reg trig_last; // Previous trigger level
  reg [7:0] wr_addr; // Data-phase write address
  reg wr_pend; // Write data due this cycle
  reg [2:0] pat_kind;
  reg [2:0] pat_count;
  reg [1:0] pat_color;
  wire [1:0] led_now;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero
  function [31:0] sled_read;
    input [7:0] a;
    begin
      case (a)
        `SLED_OFS_CTRL: sled_read = {30'h0, ctrl};
        `SLED_OFS_COND: sled_read = {23'h0, cond};
        `SLED_OFS_IRQ_STAT: sled_read = {23'h0, irq_stat};
        `SLED_OFS_IRQ_MASK: sled_read = {23'h0, irq_mask};
        `SLED_OFS_LED_STATE: sled_read = {16'h0, seq, pat_kind, pat_count, pat_color,
          led_red, led_green, 3'h0};
        default: sled_read = 32'h0000_0000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  wire addr_ok = hsel && htrans[1] && hready;
  wire wr_now = wr_pend;
  wire cond_clr_wr = wr_now && (wr_addr == `SLED_OFS_COND);
  wire stat_clr_wr = wr_now && (wr_addr == `SLED_OFS_IRQ_STAT);

  // Address phase captured; reads answered from the next data phase
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr <= haddr;
      if (addr_ok && !hwrite)
        hrdata <= sled_read(haddr);
    end
  end

  // Plain read-write registers
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl <= `SLED_CTRL_RESET;
      irq_mask <= 9'h000;
    end
    else if (wr_now)
    begin
      if (wr_addr == `SLED_OFS_CTRL)
        ctrl <= hwdata[1:0];
      if (wr_addr == `SLED_OFS_IRQ_MASK)
        irq_mask <= hwdata[8:0];
    end
  end

  // ----------------------------------------------------------------
  // Line-trigger watchdog
  // ----------------------------------------------------------------
  wire trig_toggle = (line_trigger_input != trig_last);
  wire trig_expired = ctrl[`SLED_CTRL_TRIG_WD] && (trig_cnt >= TRIG_TIMEOUT - 32'h1);

  // Counter saturates so the error keeps asserting while idle
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trig_last <= 1'b0;
      trig_cnt <= 32'h0000_0000;
    end
    else
    begin
      trig_last <= line_trigger_input;
      if (trig_toggle)
        trig_cnt <= 32'h0000_0000;
      else if (!trig_expired)
        trig_cnt <= trig_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Condition latches
  // ----------------------------------------------------------------
  // Checks only run once boot is over and software allows them;
  // overvoltage is never gated since it protects the sensor
  wire checks_on = boot_done && ctrl[`SLED_CTRL_CHECKS];
  wire [8:0] set_vec;
  wire [8:0] hw_clr;
  assign set_vec[`SLED_C_OVP] = ovp_flag;
  assign set_vec[`SLED_C_GEN] = checks_on && gen_error;
  assign set_vec[`SLED_C_FW] = checks_on && (fw_missing || fw_boot_fail);
  assign set_vec[`SLED_C_PSET] = checks_on && pset_bad;
  assign set_vec[`SLED_C_PARAM] = checks_on && param_bad;
  assign set_vec[`SLED_C_SERIAL] = checks_on && (|serial_fault);
  assign set_vec[`SLED_C_GEN3] = checks_on && gen3_error;
  assign set_vec[`SLED_C_RATE] = checks_on && line_rate_over;
  assign set_vec[`SLED_C_TRIG] = checks_on && trig_expired;
  assign hw_clr[`SLED_C_OVP] = 1'b0;
  assign hw_clr[`SLED_C_GEN3] = gen_ok;
  assign hw_clr[`SLED_C_TRIG] = trig_toggle;
  assign hw_clr[5:1] = 5'h00;
  assign hw_clr[`SLED_C_RATE] = 1'b0;

  localparam [8:0] SW_CLR = `SLED_SW_CLR_MASK; // Bits software may clear
  genvar gi;
  generate
    for (gi = 0; gi < `SLED_NCOND; gi = gi + 1)
    begin : g_cond
      wire sw_clr = cond_clr_wr && hwdata[gi] && SW_CLR[gi];
      // Each latch holds until its own clear; a set in the clear
      // cycle wins. Overvoltage has no clear but reset
      always @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          cond[gi] <= 1'b0;
        else if (set_vec[gi])
          cond[gi] <= 1'b1;
        else if (sw_clr || hw_clr[gi])
          cond[gi] <= 1'b0;
      end

      // Rising condition marks a sticky interrupt bit
      always @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          irq_stat[gi] <= 1'b0;
        else if (set_vec[gi] && !cond[gi])
          irq_stat[gi] <= 1'b1;
        else if (stat_clr_wr && hwdata[gi])
          irq_stat[gi] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Power-on sequence
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seq <= S_GREEN;
      seq_cnt <= 32'h0000_0000;
    end
    else
    begin
      case (seq)
        S_GREEN:
        begin
          // Solid green for several seconds
          if (seq_cnt >= GREEN_CYC - 32'h1)
          begin
            seq <= S_OFLASH;
            seq_cnt <= 32'h0000_0000;
          end
          else
            seq_cnt <= seq_cnt + 32'h1;
        end
        S_OFLASH:
        begin
          if (seq_cnt >= OFLASH_CYC - 32'h1)
          begin
            seq <= S_RUN;
            seq_cnt <= 32'h0000_0000;
          end
          else
            seq_cnt <= seq_cnt + 32'h1;
        end
        S_RUN:
          seq_cnt <= 32'h0000_0000;
        default:
        begin
          seq <= S_GREEN;
          seq_cnt <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Priority selection of the shown pattern
  // ----------------------------------------------------------------
  // Errors outrank the busy indication; overvoltage outranks even
  // the power-on sequence so a bad supply is never hidden
  always @*
  begin
    pat_kind = `SLED_K_SOLID;
    pat_count = 3'h0;
    pat_color = `SLED_COL_ORANGE;
    if (cond[`SLED_C_OVP])
    begin
      pat_kind = `SLED_K_FAST;
      pat_color = `SLED_COL_RED;
    end
    else if (seq == S_GREEN)
      pat_color = `SLED_COL_GREEN;
    else if (seq == S_OFLASH)
      pat_kind = `SLED_K_SLOW;
    else if (cond[`SLED_C_GEN])
      pat_kind = `SLED_K_FAST;
    else if (cond[`SLED_C_FW])
      pat_kind = `SLED_K_SLOW;
    else if (cond[`SLED_C_PSET])
    begin
      pat_kind = `SLED_K_GROUP;
      pat_count = 3'h6;
    end
    else if (cond[`SLED_C_PARAM])
    begin
      pat_kind = `SLED_K_GROUP;
      pat_count = 3'h5;
    end
    else if (cond[`SLED_C_SERIAL])
    begin
      pat_kind = `SLED_K_GROUP;
      pat_count = 3'h4;
    end
    else if (cond[`SLED_C_GEN3])
    begin
      pat_kind = `SLED_K_GROUP;
      pat_count = 3'h3;
    end
    else if (cond[`SLED_C_RATE] || cond[`SLED_C_TRIG])
    begin
      pat_kind = `SLED_K_GROUP;
      pat_count = 3'h2;
    end
    else if (busy)
      pat_kind = `SLED_K_RAMP;
  end

  sled_flash
  #(
    .FAST_HALF(FAST_HALF),
    .SLOW_HALF(SLOW_HALF),
    .GAP(GAP),
    .RAMP_START(RAMP_START),
    .RAMP_MIN(RAMP_MIN),
    .RAMP_STEP(RAMP_STEP)
  )
  u_flash
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .kind(pat_kind),
    .count(pat_count),
    .color(pat_color),
    .led(led_now)
  );

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Sensor power drops as soon as overvoltage latches; serial and
  // test images are outside this block and keep running
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      led_green <= 1'b0;
      led_red <= 1'b0;
      sensor_power_en <= 1'b0;
      live_image_en <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      led_green <= led_now[0];
      led_red <= led_now[1];
      sensor_power_en <= !cond[`SLED_C_OVP] && !ovp_flag;
      live_image_en <= !cond[`SLED_C_OVP] && !ovp_flag;
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule // sled_top

// >>> tb/sled_top_properties.sv
// Port-level checks for the status LED indicator
`timescale 1ns/1ns

module sled_props
#(
  parameter GREEN_CYC = 20,
  parameter FAST_HALF = 2
)
(
  input wire core_clk,
  input wire arst_n,
  input wire ovp_flag,
  input wire busy,
  input wire led_green,
  input wire led_red,
  input wire sensor_power_en,
  input wire live_image_en
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  reg [15:0] since_rst; // Cycles since reset release, saturating
  reg [15:0] red_len; // Length of the running red-lit stretch

  // Counters restart with reset so the power-on window is measured afresh
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      since_rst <= 16'h0000;
      red_len <= 16'h0000;
    end
    else
    begin
      if (since_rst != 16'hffff)
        since_rst <= since_rst + 16'h0001;
      red_len <= led_red ? red_len + 16'h0001 : 16'h0000;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ovp_power_off;
    ovp_flag |=> !sensor_power_en && !live_image_en;
  endproperty
  a_ovp_power_off: assert property (p_ovp_power_off)
    else $error("sensor power stayed on during overvoltage");

  property p_live_needs_power;
    live_image_en |-> sensor_power_en;
  endproperty
  a_live_needs_power: assert property (p_live_needs_power)
    else $error("live imaging allowed without sensor power");

  property p_ovp_latched;
    $fell(sensor_power_en) |=> (!sensor_power_en) [*8];
  endproperty
  a_ovp_latched: assert property (p_ovp_latched)
    else $error("overvoltage indication released before reset");

  property p_ovp_red;
    $fell(sensor_power_en) |-> ##[1:6] (!led_green) [*8];
  endproperty
  a_ovp_red: assert property (p_ovp_red)
    else $error("green shown while overvoltage latched");

  // Red alone is reserved for overvoltage; every other pattern is green or orange
  property p_red_needs_ovp;
    led_red && !led_green |-> !sensor_power_en;
  endproperty
  a_red_needs_ovp: assert property (p_red_needs_ovp)
    else $error("red shown without overvoltage");

  // Skip the first red stretch, it may merge with an earlier orange lit phase
  property p_red_fast;
    $fell(led_red) && !sensor_power_en && !$past(sensor_power_en, 8) |-> red_len == FAST_HALF;
  endproperty
  a_red_fast: assert property (p_red_fast)
    else $error("red flash length differs from fast half period");

  property p_green_first;
    sensor_power_en && since_rst >= 16'h0002 && since_rst < GREEN_CYC - 2 |->
      led_green && !led_red;
  endproperty
  a_green_first: assert property (p_green_first)
    else $error("LED not solid green after reset");

  property p_orange_pair;
    sensor_power_en && !busy && !$past(busy, 4) && since_rst > GREEN_CYC + 4 |->
      led_green == led_red;
  endproperty
  a_orange_pair: assert property (p_orange_pair)
    else $error("colour lines split outside overvoltage");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_red: cover property (!sensor_power_en && led_red);
  c_solid: cover property ((led_green && led_red) [*8]);
  c_busy: cover property (busy && $fell(led_green));
endmodule // sled_props

// >>> tb/sled_eye.sv
// Operator model: watches the LED and reads flash length, colour and group size
`timescale 1ns/1ns

module sled_eye
#(
  parameter GAP_MIN = 12
)
(
  input wire core_clk,
  input wire led_green,
  input wire led_red,
  output reg [7:0] lit_len,
  output reg [7:0] group_len,
  output reg [1:0] col
);
  integer run = 0; // Lit cycles of current flash
  integer dark = 0; // Dark cycles since last lit
  integer cnt = 0; // Flashes since last long gap

  initial
  begin
    lit_len = 8'h00;
    group_len = 8'h00;
    col = 2'h0;
  end

  // A dark stretch of GAP_MIN ends a group; shorter ones split flashes
  always @(posedge core_clk)
  begin
    if (led_green | led_red)
    begin
      if (dark != 0)
        cnt = cnt + 1;
      run = run + 1;
      dark = 0;
      col <= {led_red, led_green};
    end
    else
    begin
      if (run != 0)
        lit_len <= run[7:0];
      run = 0;
      dark = dark + 1;
      if (dark == GAP_MIN)
      begin
        group_len <= cnt[7:0];
        cnt = 0;
      end
    end
  end
endmodule // sled_eye

// >>> tb/tb.sv
// Self-checking bench for the status LED indicator
`timescale 1ns/1ns

module tb;
  localparam GREEN_CYC = 20;
  localparam OFLASH_CYC = 20;
  localparam FAST_HALF = 2;
  localparam SLOW_HALF = 4;
  localparam GAP = 20;
  localparam RAMP_MIN = 2;
  localparam TRIG_TIMEOUT = 50;
  reg core_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, busy = 1'b0;
  reg trig_run = 1'b1, line_trigger_input = 1'b0; // Trigger toggles while trig_run
  reg boot = 1'b1; // Boot finished flag
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'h0;
  reg [31:0] hwdata = 32'h0;
  reg [8:0] src = 9'h000; // ovp, gen, fw, fwboot, pset, param, gen3, rate, gen_ok
  reg [6:0] ser = 7'h00;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq, led_green, led_red, sensor_power_en, live_image_en;
  wire [7:0] eye_lit, eye_grp;
  wire [1:0] eye_col;
  integer fail_count = 0, n_tests = 0;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (trig_run)
      line_trigger_input <= ~line_trigger_input;

  sled_top #(.GREEN_CYC(GREEN_CYC), .OFLASH_CYC(OFLASH_CYC), .FAST_HALF(FAST_HALF),
    .SLOW_HALF(SLOW_HALF), .GAP(GAP), .RAMP_START(10), .RAMP_MIN(RAMP_MIN), .RAMP_STEP(2),
    .TRIG_TIMEOUT(TRIG_TIMEOUT)) i_dut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .boot_done(boot), .ovp_flag(src[0]), .gen_error(src[1]), .fw_missing(src[2]),
    .fw_boot_fail(src[3]), .pset_bad(src[4]), .param_bad(src[5]), .serial_fault(ser),
    .gen3_error(src[6]), .gen_ok(src[8]), .busy(busy), .line_rate_over(src[7]),
    .line_trigger_input(line_trigger_input), .led_green(led_green), .led_red(led_red),
    .sensor_power_en(sensor_power_en), .live_image_en(live_image_en), .irq(irq));
  sled_eye #(.GAP_MIN(12)) i_eye (.core_clk(core_clk), .led_green(led_green),
    .led_red(led_red), .lit_len(eye_lit), .group_len(eye_grp), .col(eye_col));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  // Bounded wait for the ready sample; a stuck bus ends the run
  task wait_rdy;
    integer k;
  begin
    @(posedge core_clk);
    for (k = 0; hreadyout !== 1'b1; k = k + 1)
    begin
      if (k == 20)
      begin
        fail_count = fail_count + 1;
        end_of_test;
      end
      @(posedge core_clk);
    end
  end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d, output [31:0] r);
  begin
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    reg [31:0] r;
  begin
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
    chk(hresp, 1'b0);
  end
  endtask
  task pulse(input [8:0] m);
  begin
    src <= m;
    @(posedge core_clk);
    src <= 9'h000;
    @(posedge core_clk);
  end
  endtask
  // Solid orange means every sampled cycle lit in both colours
  task solid;
    integer k, s;
  begin
    s = 0;
    cyc(5);
    for (k = 0; k < 30; k = k + 1)
    begin
      @(posedge core_clk);
      s = s + (led_green & led_red);
    end
    chk(s, 30);
  end
  endtask
  // Two full groups pass so the first, possibly merged, one is ignored
  task grp(input integer n);
  begin
    cyc(2 * (n * 2 * SLOW_HALF + GAP) + 12);
    chk(eye_grp, n);
    chk(eye_col, 2'h3);
  end
  endtask
  task do_reset;
  begin
    arst_n <= 1'b0;
    cyc(3);
    arst_n <= 1'b1;
    @(posedge core_clk);
  end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_poweron;
  begin
    cyc(2);
    chk({led_red, led_green}, 2'h1);
    chk(sensor_power_en & live_image_en, 1'b1);
    rd_chk(8'h00, 32'h3);
    rd_chk(8'h0c, 32'h0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h20, 32'h0);
    cyc(GREEN_CYC + 4);
    chk(eye_col, 2'h3);
    cyc(OFLASH_CYC);
    solid;
  end
  endtask
  // One condition: latch visible, pattern shown, cleared by write of one
  task one(input [8:0] m, input integer b, input integer n);
  begin
    pulse(m);
    rd_chk(8'h04, 32'h1 << b);
    if (n > 1)
      grp(n);
    else
    begin
      cyc(20);
      chk(eye_lit, n ? SLOW_HALF : FAST_HALF);
      chk(eye_col, 2'h3);
    end
    wr(8'h04, 32'h1 << b);
    rd_chk(8'h04, 32'h0);
    solid;
  end
  endtask
  // Every fault flag, start-byte and check-byte faults included
  task t_serial;
    integer j;
  begin
    for (j = 0; j < 7; j = j + 1)
    begin
      ser <= 7'h01 << j;
      @(posedge core_clk);
      ser <= 7'h00;
      @(posedge core_clk);
      rd_chk(8'h04, 32'h20);
      if (j < 6)
        wr(8'h04, 32'h20);
    end
    grp(4);
    wr(8'h04, 32'h20);
    solid;
  end
  endtask
  task t_prio;
  begin
    wr(8'h08, 32'h1ff);
    wr(8'h0c, 32'h8);
    pulse(9'h0d0);
    grp(6);
    chk(irq, 1'b1);
    rd_chk(8'h08, 32'hc8);
    wr(8'h04, 32'h8);
    grp(3);
    wr(8'h04, 32'h40);
    rd_chk(8'h04, 32'hc0);
    pulse(9'h100);
    rd_chk(8'h04, 32'h80);
    grp(2);
    wr(8'h04, 32'h80);
    wr(8'h0c, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    wr(8'h08, 32'hc8);
    rd_chk(8'h08, 32'h0);
    wr(8'h00, 32'h2);
    pulse(9'h020);
    rd_chk(8'h04, 32'h0);
    wr(8'h00, 32'h3);
    // Checks stay off until boot has finished
    boot <= 1'b0;
    pulse(9'h020);
    rd_chk(8'h04, 32'h0);
    boot <= 1'b1;
  end
  endtask
  task t_trig;
  begin
    trig_run <= 1'b0;
    cyc(TRIG_TIMEOUT - 10);
    rd_chk(8'h04, 32'h0);
    cyc(15);
    rd_chk(8'h04, 32'h100);
    grp(2);
    trig_run <= 1'b1;
    cyc(3);
    rd_chk(8'h04, 32'h0);
    solid;
  end
  endtask
  task t_busy;
  begin
    busy <= 1'b1;
    cyc(30);
    chk(eye_lit > RAMP_MIN, 1'b1);
    cyc(80);
    chk(eye_lit, RAMP_MIN);
    busy <= 1'b0;
    solid;
  end
  endtask
  task t_ovp;
  begin
    pulse(9'h002);
    src <= 9'h001;
    cyc(3);
    chk(sensor_power_en | live_image_en, 1'b0);
    src <= 9'h000;
    cyc(30);
    chk(eye_col, 2'h2);
    chk(eye_lit, FAST_HALF);
    rd_chk(8'h04, 32'h3);
    do_reset;
    cyc(2);
    chk({led_red, led_green, sensor_power_en}, 3'h3);
  end
  endtask

  initial
  begin
    do_reset;
    t_poweron;
    one(9'h002, 1, 0);
    one(9'h004, 2, 1);
    one(9'h008, 2, 1);
    one(9'h010, 3, 6);
    one(9'h020, 4, 5);
    one(9'h080, 7, 2);
    t_serial;
    t_prio;
    t_trig;
    t_busy;
    t_ovp;
    end_of_test;
  end
endmodule // tb

bind sled_top sled_props #(.GREEN_CYC(GREEN_CYC), .FAST_HALF(FAST_HALF)) i_props (
  .core_clk(core_clk), .arst_n(arst_n), .ovp_flag(ovp_flag), .busy(busy),
  .led_green(led_green), .led_red(led_red), .sensor_power_en(sensor_power_en),
  .live_image_en(live_image_en));
